// ---- src/wdu_pkg.sv ----
// package of the watchdog and wake-up unit: register map, field layout,
// reset values, timing counts and the power state encoding
// assumes: imported by the unit top and by its watchdog counter
package wdu_pkg;
  // ==================================================
  // widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned CNT_W = 18;
  // ==================================================
  // register byte addresses
  localparam logic [ADDR_W-1:0] OFF_DOG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SYS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WAKE = 8'h0c;
  // ==================================================
  // watchdog_control layout and values
  localparam logic [7:0] DOG_RST = 8'h53;
  localparam int unsigned GUARD_HI = 7;
  localparam int unsigned GUARD_LO = 3;
  localparam int unsigned SEL_HI = 2;
  localparam logic [4:0] GUARD_A = 5'h15;
  localparam logic [4:0] GUARD_B = 5'h0a;
  // ==================================================
  // system_control_flags and status bit positions
  localparam int unsigned KEEP_BIT = 7;
  localparam int unsigned FSEL_HI = 5;
  localparam int unsigned FSEL_LO = 4;
  localparam int unsigned BOR_BIT = 2;
  localparam int unsigned BORC_BIT = 1;
  localparam int unsigned GRF_BIT = 0;
  localparam int unsigned TO_BIT = 0;
  localparam int unsigned PDF_BIT = 1;
  // ==================================================
  // timing, in sub clock ticks and system clock cycles
  localparam logic [1:0] DEB_TICKS = 2'h2;
  localparam logic [4:0] START_FAST = 5'h0f;
  localparam logic [4:0] START_SLOW = 5'h01;
  // ==================================================
  // power states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_START = 3'b100
  } pwr_state_t;
  // low bits that must all be one for a wrap
  function automatic logic [CNT_W-1:0] period_mask(input logic [SEL_W-1:0] sel);
    case (sel)
      3'h0: period_mask = 18'h000ff;
      3'h1: period_mask = 18'h003ff;
      3'h2: period_mask = 18'h00fff;
      3'h3: period_mask = 18'h03fff;
      3'h4: period_mask = 18'h07fff;
      3'h5: period_mask = 18'h0ffff;
      3'h6: period_mask = 18'h1ffff;
      default: period_mask = 18'h3ffff;
    endcase
  endfunction : period_mask
endpackage : wdu_pkg

// ---- src/dog_if.sv ----
// interface between the unit top and its watchdog counter
// assumes: both ends run on pclk
interface dog_if;
  import wdu_pkg::*;
  logic tick;
  logic clear;
  logic [SEL_W-1:0] sel;
  logic overflow;
  logic [CNT_W-1:0] count;
  modport ctl (output tick, output clear, output sel, input overflow, input count);
  modport cnt (input tick, input clear, input sel, output overflow, output count);
endinterface : dog_if

// ---- src/dog_counter.sv ----
// watchdog counter: 18 bits advanced by sub clock ticks
// assumes: tick is a one-cycle pulse on pclk, clear comes from the top
module dog_counter (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  dog_if.cnt d // tick, clear, select, overflow
);
  import wdu_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t s_ff;
  cnt_state_t nxt_s;
  logic [CNT_W-1:0] mask;

  // ==================================================
  // overflow when the selected low bits wrap
  assign mask = period_mask(d.sel);
  assign d.overflow = d.tick & ((s_ff.cnt & mask) == mask);
  assign d.count = s_ff.cnt;

  // next count: clear or wrap to zero, else count ticks
  always_comb begin
    nxt_s = s_ff;
    if (d.clear | d.overflow) begin
      nxt_s.cnt = '0;
    end else if (d.tick) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==================================================
  // checks
  cnt_clear_a: assert property (@(posedge pclk) disable iff (!presetn) d.clear |=> d.count == '0)
    else $error("counter not zero after clear");
  cnt_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    d.overflow |-> ((d.count & period_mask(d.sel)) == period_mask(d.sel)) ##1 d.count == '0)
    else $error("overflow without full selected bits");
endmodule : dog_counter

// ---- src/watchdog_and_wakeup_unit.sv ----
// watchdog and wake-up unit: watchdog timing, guard field check,
// timeout and power-down flags, halt entry and wake-up sequencing
// assumes: core gives halt and clear pulses on pclk, sub clock and
// port pins are asynchronous, APB master drives the registers
module watchdog_and_wakeup_unit (
  input wire logic pclk, // system clock, 250 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [wdu_pkg::ADDR_W-1:0] paddr, // apb address
  input wire logic [wdu_pkg::DATA_W-1:0] pwdata, // apb write data
  output logic [wdu_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic sub_clock_pin, // slow oscillator clock
  input wire logic [wdu_pkg::PORT_W-1:0] port_pins, // port pins
  input wire logic halt_instr, // halt executed
  input wire logic halt_idle_sel, // halt goes to idle
  input wire logic dog_clear_instr, // watchdog clear executed
  input wire logic [wdu_pkg::IRQ_W-1:0] irq_req, // request flags
  input wire logic [wdu_pkg::IRQ_W-1:0] irq_en, // interrupt enables
  input wire logic stack_full, // no free stack level
  input wire logic sysclk_fast, // system clock from fast osc
  output logic sysclk_keep_on, // keep clock in idle
  output logic [1:0] fast_osc_freq_select, // fast osc frequency
  output logic halted, // core stopped
  output logic halt_clock_on, // idle with clock running
  output logic chip_reset, // device reset pulse
  output logic pc_sp_clear, // clear pc and sp pulse
  output logic wake_resume, // resume after halt pulse
  output logic wake_irq_take, // interrupt response pulse
  output logic timeout_flag, // watchdog timeout flag
  output logic power_down_flag // power-down flag
);
  import wdu_pkg::*;

  typedef struct packed {
    logic sub_s1;
    logic sub_s2;
    logic sub_prev;
    logic [PORT_W-1:0] pin_s1;
    logic [PORT_W-1:0] pin_s2;
    logic [PORT_W-1:0] pin_last;
    logic [7:0] dog_ctl;
    logic keep_on;
    logic [1:0] fsel;
    logic bor_f;
    logic borc_f;
    logic guard_f;
    logic [PORT_W-1:0] wake_en;
    logic to_f;
    logic pdf_f;
    pwr_state_t st;
    logic idle_sel;
    logic [IRQ_W-1:0] arm;
    logic from_dog;
    logic irq_go;
    logic [4:0] delay;
    logic [1:0] deb;
    logic chip_rst;
    logic pcsp_clr;
    logic resume;
    logic irq_take;
    logic [DATA_W-1:0] rdata;
  } unit_t;

  unit_t s_ff;
  unit_t nxt_s;
  logic nxt_clr;
  logic tick;
  logic [PORT_W-1:0] pin_fall;
  logic [4:0] guard;
  logic guard_ok;
  logic wr;
  logic rd_setup;
  logic mapped;
  logic irq_wake;
  logic ovf;

  dog_if d ();

  // ==================================================
  // watchdog counter
  dog_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .d(d.cnt)
  );

  // counter runs on every tick, no way to stop it
  assign d.tick = tick;
  assign d.sel = s_ff.dog_ctl[SEL_HI:0];
  assign d.clear = nxt_clr;
  assign ovf = d.overflow;

  // ==================================================
  // decoded conditions
  assign tick = s_ff.sub_s2 & ~s_ff.sub_prev;
  assign pin_fall = {PORT_W{tick}} & s_ff.pin_last & ~s_ff.pin_s2 & s_ff.wake_en;
  assign guard = s_ff.dog_ctl[GUARD_HI:GUARD_LO];
  assign guard_ok = (guard == GUARD_A) | (guard == GUARD_B);
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = (paddr == OFF_DOG) | (paddr == OFF_SYS) | (paddr == OFF_STAT) | (paddr == OFF_WAKE);
  assign irq_wake = |(irq_req & s_ff.arm);

  // ==================================================
  // next state
  always_comb begin
    logic [7:0] sysv;
    logic [7:0] statv;
    sysv = '0;
    statv = '0;
    nxt_s = s_ff;
    nxt_clr = 1'b0;
    nxt_s.chip_rst = 1'b0;
    nxt_s.pcsp_clr = 1'b0;
    nxt_s.resume = 1'b0;
    nxt_s.irq_take = 1'b0;
    // two-flop synchronisers, pins held per tick
    nxt_s.sub_s1 = sub_clock_pin;
    nxt_s.sub_s2 = s_ff.sub_s1;
    nxt_s.sub_prev = s_ff.sub_s2;
    nxt_s.pin_s1 = port_pins;
    nxt_s.pin_s2 = s_ff.pin_s1;
    if (tick) begin
      nxt_s.pin_last = s_ff.pin_s2;
    end
    // register writes in the access phase
    if (wr && paddr == OFF_DOG) begin
      nxt_s.dog_ctl = pwdata[7:0];
    end else if (wr && paddr == OFF_SYS) begin
      nxt_s.keep_on = pwdata[KEEP_BIT];
      nxt_s.fsel = pwdata[FSEL_HI:FSEL_LO];
      nxt_s.bor_f = s_ff.bor_f & pwdata[BOR_BIT];
      nxt_s.borc_f = s_ff.borc_f & pwdata[BORC_BIT];
      nxt_s.guard_f = s_ff.guard_f & pwdata[GRF_BIT];
    end else if (wr && paddr == OFF_WAKE) begin
      nxt_s.wake_en = pwdata[PORT_W-1:0];
    end
    // read data captured in the setup cycle
    sysv[KEEP_BIT] = s_ff.keep_on;
    sysv[FSEL_HI:FSEL_LO] = s_ff.fsel;
    sysv[BOR_BIT] = s_ff.bor_f;
    sysv[BORC_BIT] = s_ff.borc_f;
    sysv[GRF_BIT] = s_ff.guard_f;
    statv[TO_BIT] = s_ff.to_f;
    statv[PDF_BIT] = s_ff.pdf_f;
    if (rd_setup) begin
      if (paddr == OFF_DOG) begin
        nxt_s.rdata = {{(DATA_W-8){1'b0}}, s_ff.dog_ctl};
      end else if (paddr == OFF_SYS) begin
        nxt_s.rdata = {{(DATA_W-8){1'b0}}, sysv};
      end else if (paddr == OFF_STAT) begin
        nxt_s.rdata = {{(DATA_W-8){1'b0}}, statv};
      end else if (paddr == OFF_WAKE) begin
        nxt_s.rdata = {{(DATA_W-PORT_W){1'b0}}, s_ff.wake_en};
      end else begin
        nxt_s.rdata = '0;
      end
    end
    // clear instruction zeroes counter and power-down flag
    if (dog_clear_instr && s_ff.st == ST_RUN) begin
      nxt_clr = 1'b1;
      nxt_s.pdf_f = 1'b0;
    end
    // power sequencing
    case (s_ff.st)
      ST_RUN: begin
        if (halt_instr) begin
          nxt_clr = 1'b1;
          nxt_s.pdf_f = 1'b1;
          nxt_s.to_f = 1'b0;
          nxt_s.st = ST_HALT;
          nxt_s.idle_sel = halt_idle_sel;
          nxt_s.arm = ~irq_req;
        end
      end
      ST_HALT: begin
        if (ovf) begin
          nxt_s.from_dog = 1'b1;
          nxt_s.irq_go = 1'b0;
          nxt_s.st = ST_START;
        end else if (irq_wake) begin
          nxt_s.from_dog = 1'b0;
          nxt_s.irq_go = (|(irq_req & s_ff.arm & irq_en)) & ~stack_full;
          nxt_s.st = ST_START;
        end else if (|pin_fall) begin
          nxt_s.from_dog = 1'b0;
          nxt_s.irq_go = 1'b0;
          nxt_s.st = ST_START;
        end
        nxt_s.delay = sysclk_fast ? START_FAST : START_SLOW;
      end
      ST_START: begin
        if (s_ff.delay == START_SLOW) begin
          nxt_s.st = ST_RUN;
          if (s_ff.from_dog) begin
            nxt_s.pcsp_clr = 1'b1;
          end else if (s_ff.irq_go) begin
            nxt_s.irq_take = 1'b1;
          end else begin
            nxt_s.resume = 1'b1;
          end
        end else begin
          nxt_s.delay = s_ff.delay - START_SLOW;
        end
      end
      default: begin
        nxt_s.st = ST_RUN;
      end
    endcase
    // overflow sets timeout flag; wins over halt clearing it
    if (ovf) begin
      nxt_s.to_f = 1'b1;
    end
    // overflow while running resets the device
    if (ovf && s_ff.st == ST_RUN) begin
      nxt_s.chip_rst = 1'b1;
      nxt_s.dog_ctl = DOG_RST;
    end
    // guard debounce, reset on the third tick
    if (guard_ok) begin
      nxt_s.deb = '0;
    end else if (tick) begin
      if (s_ff.deb == DEB_TICKS) begin
        nxt_s.deb = '0;
        nxt_s.chip_rst = 1'b1;
        nxt_s.guard_f = 1'b1;
        nxt_s.dog_ctl = DOG_RST;
        nxt_s.st = ST_RUN;
        nxt_clr = 1'b1;
      end else begin
        nxt_s.deb = s_ff.deb + 1'b1;
      end
    end
  end

  // ==================================================
  // state register; power-on gives clean flags, run state and the DOG_RST control value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.st <= ST_RUN;
      s_ff.dog_ctl <= DOG_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==================================================
  // outputs
  assign prdata = s_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign sysclk_keep_on = s_ff.keep_on;
  assign fast_osc_freq_select = s_ff.fsel;
  assign halted = s_ff.st != ST_RUN;
  assign halt_clock_on = (s_ff.st == ST_HALT) & s_ff.idle_sel & s_ff.keep_on;
  assign chip_reset = s_ff.chip_rst;
  assign pc_sp_clear = s_ff.pcsp_clr;
  assign wake_resume = s_ff.resume;
  assign wake_irq_take = s_ff.irq_take;
  assign timeout_flag = s_ff.to_f;
  assign power_down_flag = s_ff.pdf_f;

  // ==================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  halt_entry_a: assert property ((s_ff.st == ST_RUN) && halt_instr && !ovf && guard_ok
    |=> (s_ff.st == ST_HALT) && s_ff.pdf_f && !s_ff.to_f && (d.count == '0))
    else $error("halt entry did not set flags");
  clear_pdf_a: assert property ((s_ff.st == ST_RUN) && dog_clear_instr && !halt_instr
    |=> !s_ff.pdf_f)
    else $error("clear did not drop power-down flag");
  run_overflow_a: assert property ((s_ff.st == ST_RUN) && ovf
    |=> chip_reset && timeout_flag ##1 !chip_reset)
    else $error("running overflow did not reset");
  halt_overflow_a: assert property ((s_ff.st == ST_HALT) && ovf && !wr && guard_ok
    |=> s_ff.to_f && s_ff.pdf_f && (s_ff.dog_ctl == $past(s_ff.dog_ctl)) && (s_ff.st == ST_START))
    else $error("halted overflow handled wrongly");
  guard_reset_a: assert property (!guard_ok && tick && (s_ff.deb == DEB_TICKS)
    |=> chip_reset && s_ff.guard_f && (s_ff.dog_ctl == DOG_RST))
    else $error("bad guard did not reset");
  fast_start_a: assert property ((s_ff.st == ST_HALT) && sysclk_fast && irq_wake && !ovf
    |=> (s_ff.st == ST_START) && (s_ff.delay == START_FAST) ##14 (s_ff.st == ST_START)
    && (s_ff.delay == START_SLOW) ##1 (s_ff.st == ST_RUN))
    else $error("fast start-up delay wrong");
  slow_start_a: assert property ((s_ff.st == ST_HALT) && !sysclk_fast && irq_wake && !ovf
    |=> (s_ff.st == ST_START) ##1 (s_ff.st == ST_RUN))
    else $error("slow start-up delay wrong");
  pin_wake_a: assert property ((s_ff.st == ST_HALT) && (|pin_fall) && guard_ok
    |=> (s_ff.st == ST_START))
    else $error("pin edge did not wake");
  armed_irq_a: assert property ((s_ff.st == ST_HALT) && !irq_wake && !(|pin_fall) && !ovf && guard_ok
    |=> (s_ff.st == ST_HALT))
    else $error("woke without a source");
  wake_kind_a: assert property ((s_ff.st == ST_START) && (s_ff.delay == START_SLOW)
    |=> (wake_irq_take == s_ff.irq_go) && (wake_resume == (!s_ff.irq_go && !s_ff.from_dog)))
    else $error("wrong wake response");
endmodule : watchdog_and_wakeup_unit

// ---- sim/core_pins_model.sv ----
// core and port pin model: free slow oscillator, pins, halt and clear
// assumes: bench owns pclk and calls the tasks right after a rising edge
module core_pins_model (
  input wire logic pclk, // system clock
  output logic sub_clock_pin, // slow oscillator
  output logic [7:0] port_pins, // pins, pulled high
  output logic halt_instr, // halt pulse
  output logic halt_idle_sel, // 1 = idle
  output logic dog_clear_instr // clear pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==================================================
  // slow oscillator runs free, phase unrelated to pclk
  initial begin
    sub_clock_pin = 1'b0;
    #1.3;
    forever #33 sub_clock_pin = ~sub_clock_pin;
  end
  // quiet levels at time zero, pins pulled high
  initial begin
    port_pins = 8'hff;
    halt_instr = 1'b0;
    halt_idle_sel = 1'b0;
    dog_clear_instr = 1'b0;
  end
  // one-cycle halt, idle or sleep chosen with it
  task automatic halt_op(input logic idle);
    @(posedge pclk);
    halt_instr <= 1'b1;
    halt_idle_sel <= idle;
    @(posedge pclk);
    halt_instr <= 1'b0;
  endtask : halt_op
  // one-cycle watchdog clear from software
  task automatic clear_op();
    @(posedge pclk);
    dog_clear_instr <= 1'b1;
    @(posedge pclk);
    dog_clear_instr <= 1'b0;
  endtask : clear_op
  // new pin levels on the next edge
  task automatic pin_op(input logic [7:0] v);
    @(posedge pclk);
    port_pins <= v;
  endtask : pin_op
endmodule : core_pins_model

// ---- sim/watchdog_and_wakeup_unit_bench.sv ----
// self-checking bench of the watchdog and wake-up unit
// assumes: apb with no wait states, core_pins_model as far side
module watchdog_and_wakeup_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import wdu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sub_clock_pin;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [PORT_W-1:0] port_pins;
  logic halt_instr, halt_idle_sel, dog_clear_instr, stack_full, sysclk_fast;
  logic [IRQ_W-1:0] irq_req, irq_en;
  logic sysclk_keep_on, halted, halt_clock_on, chip_reset, pc_sp_clear;
  logic wake_resume, wake_irq_take, timeout_flag, power_down_flag, er, found, idl;
  logic [1:0] fosc;
  logic [3:0] kind;
  logic [7:0] r8;
  int fails, checks_done, cyc, k, b, dfast, dslow;
  // ==================================================
  // design and far side
  watchdog_and_wakeup_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_clock_pin(sub_clock_pin), .port_pins(port_pins),
    .halt_instr(halt_instr), .halt_idle_sel(halt_idle_sel), .dog_clear_instr(dog_clear_instr),
    .irq_req(irq_req), .irq_en(irq_en), .stack_full(stack_full), .sysclk_fast(sysclk_fast),
    .sysclk_keep_on(sysclk_keep_on), .fast_osc_freq_select(fosc), .halted(halted),
    .halt_clock_on(halt_clock_on), .chip_reset(chip_reset), .pc_sp_clear(pc_sp_clear),
    .wake_resume(wake_resume), .wake_irq_take(wake_irq_take), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag));
  core_pins_model core (.pclk(pclk), .sub_clock_pin(sub_clock_pin), .port_pins(port_pins),
    .halt_instr(halt_instr), .halt_idle_sel(halt_idle_sel), .dog_clear_instr(dog_clear_instr));
  // ==================================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, exp, rd);
  endtask : rchk
  // bounded wait for any outcome pulse
  task automatic wait_any(input int lim, input logic need);
    found = 1'b0;
    cyc = 0;
    while (!found && cyc < lim) begin
      @(posedge pclk);
      cyc++;
      kind = {chip_reset, pc_sp_clear, wake_irq_take, wake_resume};
      found = (kind !== 4'h0);
    end
    // a needed pulse that never comes ends the run
    if (need && !found) begin
      fails++;
      $display("BAD wait_any expected pulse seen none");
      tally_and_finish();
    end
  endtask : wait_any
  // expected wake kind per interrupt table row
  function automatic logic [31:0] exp_kind(input int row);
    exp_kind = (row < 2) ? 32'h2 : 32'h1;
  endfunction : exp_kind
  // ==================================================
  // clock and run limit
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, stack_full, sysclk_fast} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    irq_req = 4'h0;
    irq_en = 4'h0;
    fails = 0;
    checks_done = 0;
    k = $urandom(32'h14af421a);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("dog reset", OFF_DOG, {24'h0, DOG_RST});
    check("mapped err", 32'h0, er);
    rchk("stat reset", OFF_STAT, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", 32'h1, er);
    check("unmapped data", 32'h0, rd);
    r8 = 8'($urandom);
    apb(1'b1, OFF_WAKE, r8);
    rchk("wake enables", OFF_WAKE, r8);
    r8 = 8'($urandom) & 8'hb0;
    apb(1'b1, OFF_SYS, r8);
    @(posedge pclk);
    check("keep on", r8[7], sysclk_keep_on);
    check("osc select", r8[5:4], fosc);
    $display("test registers done");
    apb(1'b1, OFF_DOG, {GUARD_B, 3'h0});
    core.clear_op();
    wait_any(3000, 1'b0);
    check("cleared no reset", 32'h0, found);
    core.clear_op();
    wait_any(5000, 1'b1);
    check("run overflow kind", 32'h8, kind);
    check("run overflow time", 32'h1, cyc >= 4190 && cyc <= 4270);
    @(posedge pclk);
    check("timeout flag", 32'h1, timeout_flag);
    rchk("dog reload", OFF_DOG, 32'h53);
    rchk("stat after run", OFF_STAT, 32'h1);
    $display("test running overflow done");
    apb(1'b1, OFF_DOG, 32'h0);
    wait_any(100, 1'b1);
    check("guard reset kind", 32'h8, kind);
    check("guard debounce", 32'h1, cyc >= 25 && cyc <= 70);
    rchk("guard flag", OFF_SYS, r8 | 32'h1);
    rchk("dog after guard", OFF_DOG, 32'h53);
    apb(1'b1, OFF_SYS, 32'h1);
    rchk("flag kept", OFF_SYS, 32'h1);
    apb(1'b1, OFF_SYS, 32'h0);
    rchk("flag cleared", OFF_SYS, 32'h0);
    $display("test guard done");
    apb(1'b1, OFF_SYS, 32'h80);
    for (k = 0; k < 4; k++) begin
      b = $urandom % 4;
      sysclk_fast <= (k != 1);
      irq_en <= (k == 2) ? 4'h0 : 4'h1 << b;
      stack_full <= (k == 3);
      idl = 1'($urandom);
      core.halt_op(idl);
      rchk("stat in halt", OFF_STAT, 32'h2);
      check("halted in halt", 32'h1, halted);
      check("clock on in idle", {31'h0, idl}, halt_clock_on);
      irq_req <= 4'h1 << b;
      wait_any(100, 1'b1);
      check("irq wake kind", exp_kind(k), kind);
      check("halted at wake", 32'h0, halted);
      if (k == 0) dfast = cyc;
      if (k == 1) dslow = cyc;
      irq_req <= 4'h0;
    end
    check("start delay gap", 32'(START_FAST - START_SLOW), 32'(dfast - dslow));
    $display("test interrupt wake done");
    irq_en <= 4'hf;
    irq_req <= 4'h4;
    k = $urandom % 8;
    apb(1'b1, OFF_WAKE, 32'h1 << k);
    core.halt_op(1'b1);
    core.pin_op(~(8'h1 << ((k + 1) % 8)));
    wait_any(200, 1'b0);
    check("no wake", 32'h0, found);
    core.pin_op(8'h00);
    wait_any(200, 1'b1);
    check("pin wake kind", 32'h1, kind);
    core.pin_op(8'hff);
    irq_req <= 4'h0;
    core.clear_op();
    rchk("pdf cleared", OFF_STAT, 32'h0);
    $display("test pin wake done");
    apb(1'b1, OFF_DOG, {GUARD_A, 3'h0});
    core.halt_op(1'b0);
    wait_any(5000, 1'b1);
    check("halted overflow kind", 32'h4, kind);
    check("halted overflow time", 32'h1, cyc >= 4190 && cyc <= 4270);
    rchk("stat halted ovf", OFF_STAT, 32'h3);
    rchk("dog kept", OFF_DOG, {24'h0, GUARD_A, 3'h0});
    $display("test halted overflow done");
    // second power-on reset in mid-run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk("stat power-on", OFF_STAT, 32'h0);
    rchk("dog power-on", OFF_DOG, {24'h0, DOG_RST});
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : watchdog_and_wakeup_unit_bench
